// File: verilog/pfs_pkg.sv
`default_nettype none
package pfs_pkg;
	// register geometry
	localparam int unsigned REG_WIDTH = 16;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// field positions of the primary fault status word
	localparam int unsigned BIT_READY = 14;
	localparam int unsigned BIT_UNDERVOLT = 13;
	localparam int unsigned BIT_OVERVOLT = 12;
	localparam int unsigned BIT_SHOOT = 11;
	localparam int unsigned BIT_ILIMIT = 10;
	localparam int unsigned BIT_SPI = 9;
	localparam int unsigned BIT_RAIL = 8;
	localparam int unsigned BIT_LINK = 7;
	localparam int unsigned BIT_SELFTEST = 6;

	// serial frames must carry a multiple of this many clock pulses
	localparam int unsigned FRAME_PULSES = 16;

	// number of asynchronous pin inputs passed through the synchroniser
	localparam int unsigned SYNC_COUNT = 9;

	// frame tracker states, one-hot
	typedef enum logic [1:0] {
		FRM_IDLE = 2'b01,
		FRM_OPEN = 2'b10
	} pfs_frame_e;
endpackage
`default_nettype wire

// File: verilog/pfs_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a bundle of asynchronous levels
module pfs_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_r;

	// refused at elaboration: an empty bundle has nothing to carry
	if (WIDTH < 1) begin
		$error("pfs_sync: WIDTH must be at least 1");
	end

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1_r <= INIT;
			syncOut <= INIT;
		end else begin
			stage1_r <= asyncIn;
			syncOut <= stage1_r;
		end
	end
endmodule
`default_nettype wire

// File: verilog/pfs_status_reg.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - bit 14 shows primary side ready
// - bit 13 set on supply undervoltage
// - bit 12 set on supply overvoltage
// - bit 11 set when both PWM inputs high
// - bit 10 set while regulator current-limits
// - bit 9 set on non-multiple-of-16 clock frame
// - bit 9 set on host CRC mismatch
// - bit 9 clears after valid command, then read
// - bit 8 set on internal rail fault
// - bit 7 set on barrier link loss
// - bit 6 set on power-up selftest failure
module pfs_status_reg (
	input wire logic clk,
	input wire logic rst_n,
	// asynchronous pins and analog comparator outputs
	input wire logic spiCsN,
	input wire logic spiSclk,
	input wire logic pwmInPos,
	input wire logic pwmInNeg,
	input wire logic supplyUnderVolt,
	input wire logic supplyOverVolt,
	input wire logic regulatorCurrentLimit,
	input wire logic internalRailFault,
	input wire logic barrierLinkLost,
	// same-clock inputs from the serial frame logic and power sequencer
	input wire logic primaryReadyIn,
	input wire logic selftestFail,
	input wire logic crcMismatch,
	input wire logic validCommand,
	input wire logic statusRead,
	// register contents as seen by the serial read path
	output logic [15:0] statusData
);
	// synchronised copies of the asynchronous inputs
	logic [pfs_pkg::SYNC_COUNT-1:0] rawPins;
	logic [pfs_pkg::SYNC_COUNT-1:0] syncPins;
	logic csNSync;
	logic sclkSync;
	logic inPosSync;
	logic inNegSync;
	logic underVoltSync;
	logic overVoltSync;
	logic iLimitSync;
	logic railSync;
	logic linkLostSync;

	// frame tracking
	pfs_pkg::pfs_frame_e frame_r, frame_nxt;
	logic sclkPrev_r;
	logic csPrev_r;
	logic [3:0] pulseCount_r, pulseCount_nxt;
	logic sclkRise;
	logic csFall;
	logic csRise;
	logic frameBad;

	// ready flag, sticky flags and the spi clear qualifier
	logic readyFlag_r;
	logic underVoltFlag_r, underVoltFlag_nxt;
	logic overVoltFlag_r, overVoltFlag_nxt;
	logic shootFlag_r, shootFlag_nxt;
	logic iLimitFlag_r, iLimitFlag_nxt;
	logic spiFlag_r, spiFlag_nxt;
	logic railFlag_r, railFlag_nxt;
	logic linkFlag_r, linkFlag_nxt;
	logic selftestFlag_r, selftestFlag_nxt;
	logic clearArmed_r, clearArmed_nxt;
	logic shootCause;
	logic spiCause;
	logic [15:0] status_nxt;

	// the four-bit pulse counter wraps at 16, so no other frame size is served
	if (pfs_pkg::FRAME_PULSES != 16) begin
		$error("pfs_status_reg: frame counter is built for 16 pulses");
	end

	// chip select idles high, so it resets high in the synchroniser
	assign rawPins = {spiCsN, spiSclk, pwmInPos, pwmInNeg, supplyUnderVolt,
		supplyOverVolt, regulatorCurrentLimit, internalRailFault, barrierLinkLost};

	pfs_sync #(
		.WIDTH(pfs_pkg::SYNC_COUNT),
		.INIT(9'h100)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.asyncIn(rawPins),
		.syncOut(syncPins)
	);

	assign csNSync = syncPins[8];
	assign sclkSync = syncPins[7];
	assign inPosSync = syncPins[6];
	assign inNegSync = syncPins[5];
	assign underVoltSync = syncPins[4];
	assign overVoltSync = syncPins[3];
	assign iLimitSync = syncPins[2];
	assign railSync = syncPins[1];
	assign linkLostSync = syncPins[0];

	// edge detection on the synchronised serial pins
	assign sclkRise = sclkSync & ~sclkPrev_r;
	assign csFall = ~csNSync & csPrev_r;
	assign csRise = csNSync & ~csPrev_r;

	// a frame that closes with a partial word is a framing fault
	assign frameBad = (frame_r == pfs_pkg::FRM_OPEN) && csRise && (pulseCount_r != 4'h0);

	// frame tracker: count pulses modulo 16 between select edges
	always_comb begin
		frame_nxt = frame_r;
		pulseCount_nxt = pulseCount_r;
		unique case (frame_r)
			pfs_pkg::FRM_IDLE: begin
				if (csFall) begin
					frame_nxt = pfs_pkg::FRM_OPEN;
					pulseCount_nxt = 4'h0;
				end
			end
			pfs_pkg::FRM_OPEN: begin
				if (csRise) begin
					frame_nxt = pfs_pkg::FRM_IDLE;
				end else if (sclkRise) begin
					pulseCount_nxt = pulseCount_r + 4'h1;
				end
			end
			default: begin
				frame_nxt = pfs_pkg::FRM_IDLE;
				pulseCount_nxt = 4'h0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_r <= pfs_pkg::FRM_IDLE;
			pulseCount_r <= 4'h0;
			sclkPrev_r <= 1'b0;
			csPrev_r <= 1'b1;
		end else begin
			frame_r <= frame_nxt;
			pulseCount_r <= pulseCount_nxt;
			sclkPrev_r <= sclkSync;
			csPrev_r <= csNSync;
		end
	end

	// fault causes
	assign shootCause = inPosSync & inNegSync;
	assign spiCause = frameBad | crcMismatch;

	// sticky flags: a read clears a flag only if that value was shown and
	// its cause is gone; a cause in the same cycle always wins
	assign underVoltFlag_nxt = underVoltSync | (underVoltFlag_r &
		~(statusRead & statusData[pfs_pkg::BIT_UNDERVOLT]));
	assign overVoltFlag_nxt = overVoltSync | (overVoltFlag_r &
		~(statusRead & statusData[pfs_pkg::BIT_OVERVOLT]));
	assign shootFlag_nxt = shootCause | (shootFlag_r &
		~(statusRead & statusData[pfs_pkg::BIT_SHOOT]));
	assign iLimitFlag_nxt = iLimitSync | (iLimitFlag_r &
		~(statusRead & statusData[pfs_pkg::BIT_ILIMIT]));
	assign railFlag_nxt = railSync | (railFlag_r &
		~(statusRead & statusData[pfs_pkg::BIT_RAIL]));
	assign linkFlag_nxt = linkLostSync | (linkFlag_r &
		~(statusRead & statusData[pfs_pkg::BIT_LINK]));
	assign selftestFlag_nxt = selftestFail | (selftestFlag_r &
		~(statusRead & statusData[pfs_pkg::BIT_SELFTEST]));

	// spi fault needs a valid command first; a new fault disarms the clear
	assign clearArmed_nxt = spiCause ? 1'b0 :
		(spiFlag_r & (clearArmed_r | validCommand));
	assign spiFlag_nxt = spiCause | (spiFlag_r &
		~(statusRead & clearArmed_r & statusData[pfs_pkg::BIT_SPI]));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readyFlag_r <= 1'b0;
			underVoltFlag_r <= 1'b0;
			overVoltFlag_r <= 1'b0;
			shootFlag_r <= 1'b0;
			iLimitFlag_r <= 1'b0;
			spiFlag_r <= 1'b0;
			railFlag_r <= 1'b0;
			linkFlag_r <= 1'b0;
			selftestFlag_r <= 1'b0;
			clearArmed_r <= 1'b0;
		end else begin
			readyFlag_r <= primaryReadyIn;
			underVoltFlag_r <= underVoltFlag_nxt;
			overVoltFlag_r <= overVoltFlag_nxt;
			shootFlag_r <= shootFlag_nxt;
			iLimitFlag_r <= iLimitFlag_nxt;
			spiFlag_r <= spiFlag_nxt;
			railFlag_r <= railFlag_nxt;
			linkFlag_r <= linkFlag_nxt;
			selftestFlag_r <= selftestFlag_nxt;
			clearArmed_r <= clearArmed_nxt;
		end
	end

	// assemble the word; bits 15 and 5..0 belong elsewhere and read zero
	always_comb begin
		status_nxt = pfs_pkg::STATUS_RESET;
		status_nxt[pfs_pkg::BIT_READY] = readyFlag_r;
		status_nxt[pfs_pkg::BIT_UNDERVOLT] = underVoltFlag_r;
		status_nxt[pfs_pkg::BIT_OVERVOLT] = overVoltFlag_r;
		status_nxt[pfs_pkg::BIT_SHOOT] = shootFlag_r;
		status_nxt[pfs_pkg::BIT_ILIMIT] = iLimitFlag_r;
		status_nxt[pfs_pkg::BIT_SPI] = spiFlag_r;
		status_nxt[pfs_pkg::BIT_RAIL] = railFlag_r;
		status_nxt[pfs_pkg::BIT_LINK] = linkFlag_r;
		status_nxt[pfs_pkg::BIT_SELFTEST] = selftestFlag_r;
	end

	// output copy: no write path exists, so nothing external alters it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			statusData <= pfs_pkg::STATUS_RESET;
		end else begin
			statusData <= status_nxt;
		end
	end
endmodule
`default_nettype wire

// File: bench/pfs_status_props.sv
`timescale 1ns/1ps
`default_nettype none
// ties each status bit to its cause
module pfs_status_props (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pwmInPos,
	input wire logic pwmInNeg,
	input wire logic supplyUnderVolt,
	input wire logic supplyOverVolt,
	input wire logic regulatorCurrentLimit,
	input wire logic internalRailFault,
	input wire logic barrierLinkLost,
	input wire logic primaryReadyIn,
	input wire logic selftestFail,
	input wire logic crcMismatch,
	input wire logic statusRead,
	input wire logic [15:0] statusData
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// pins pass a synchroniser, so they lag two edges more than same-clock causes
	property pLag2(c, q); c |-> ##2 q; endproperty
	property pLag4(c, q); c |-> ##4 q; endproperty
	sequence sBoth; pwmInPos && pwmInNeg; endsequence
	sequence sReadAgo; $past(statusRead, 2); endsequence
	AST_RDY: assert property (statusData[14] == $past(primaryReadyIn, 2)) else $error("ready");
	AST_UV: assert property (pLag4(supplyUnderVolt, statusData[13])) else $error("uv");
	AST_OV: assert property (pLag4(supplyOverVolt, statusData[12])) else $error("ov");
	AST_SHOOT: assert property (sBoth |-> ##4 statusData[11]) else $error("shoot");
	AST_ILIM: assert property (pLag4(regulatorCurrentLimit, statusData[10])) else $error("ilimit");
	AST_CRC: assert property (pLag2(crcMismatch, statusData[9])) else $error("crc");
	AST_RAIL: assert property (pLag4(internalRailFault, statusData[8])) else $error("rail");
	AST_LINK: assert property (pLag4(barrierLinkLost, statusData[7])) else $error("link");
	AST_SPIHOLD: assert property ($fell(statusData[9]) |-> sReadAgo) else $error("spi drop");
	AST_SELF: assert property (pLag2(selftestFail, statusData[6])) else $error("selftest");
	AST_RSVD: assert property (statusData[15] == 1'h0 && statusData[5:0] == 6'h00) else $error("rsvd");
endmodule
bind pfs_status_reg pfs_status_props u_props (.clk, .rst_n, .pwmInPos, .pwmInNeg, .supplyUnderVolt,
	.supplyOverVolt, .regulatorCurrentLimit, .internalRailFault, .barrierLinkLost, .primaryReadyIn, .selftestFail,
	.crcMismatch, .statusRead, .statusData);
`default_nettype wire

// File: bench/pfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host serial pins; clock rests low between frames
module pfs_host_model (
	input wire logic clk,
	output logic csN,
	output logic sclk
);
	initial begin
		csN = 1'h1;
		sclk = 1'h0;
	end
	// four clocks per phase, slow enough for the synchroniser
	task automatic frame(input int n);
		@(negedge clk) csN = 1'h0;
		repeat (4) @(negedge clk);
		for (int i = 0; i < n; i++) begin
			sclk = 1'h1;
			repeat (4) @(negedge clk);
			sclk = 1'h0;
			repeat (4) @(negedge clk);
		end
		csN = 1'h1;
		repeat (12) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// File: bench/primary_side_fault_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module primary_side_fault_status_tb;
	logic clk, rst_n, spiCsN, spiSclk, r, primaryReadyIn;
	logic selftestFail, crcMismatch, validCommand, statusRead;
	logic [5:0] flt;
	logic [15:0] statusData;
	int num_errors, compares, seed, n;
	int pos [6] = '{13, 12, 10, 8, 7, 11};
	// pwm inputs toggle at random but meet only when a shoot-through is wanted
	wire logic pwmInPos = flt[5] | r;
	wire logic pwmInNeg = flt[5] | ~r;
	pfs_status_reg u_dut (.clk, .rst_n, .spiCsN, .spiSclk, .pwmInPos, .pwmInNeg, .supplyUnderVolt(flt[0]),
		.supplyOverVolt(flt[1]), .regulatorCurrentLimit(flt[2]), .internalRailFault(flt[3]),
		.barrierLinkLost(flt[4]), .primaryReadyIn, .selftestFail, .crcMismatch, .validCommand, .statusRead,
		.statusData);
	pfs_host_model u_host (.clk, .csN(spiCsN), .sclk(spiSclk));
	function logic bad(int k);
		return k % 16 != 0;
	endfunction
	task wt(int k);
		repeat (k) @(negedge clk) r = 1'($random(seed));
	endtask
	task check(string nm, logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one-cycle strobes: selftest, command, crc, read
	task strobe(logic [3:0] m);
		@(negedge clk) {selftestFail, validCommand, crcMismatch, statusRead} = m;
		@(negedge clk) {selftestFail, validCommand, crcMismatch, statusRead} = 4'h0;
		wt(4);
	endtask
	task results;
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	// hang guard
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		results;
	end
	initial begin
		seed = 20239;
		{rst_n, r, flt, primaryReadyIn, selftestFail, crcMismatch, validCommand, statusRead} = '0;
		wt(3);
		rst_n = 1'h1;
		check("reset", statusData, 16'h0000);
		primaryReadyIn = 1'h1;
		wt(3);
		check("ready", statusData[14], 1'h1);
		primaryReadyIn = 1'h0;
		wt(3);
		check("not ready", statusData[14], 1'h0);
		// level faults survive a read while present, clear on one after
		for (int i = 0; i < 6; i++) begin
			flt[i] = 1'h1;
			wt(6);
			strobe(4'h1);
			check("held", statusData[pos[i]], 1'h1);
			flt[i] = 1'h0;
			wt(6);
			check("sticky", statusData[pos[i]], 1'h1);
			strobe(4'h1);
			check("cleared", statusData, 16'h0000);
		end
		strobe(4'h8);
		check("selftest", statusData[6], 1'h1);
		strobe(4'h1);
		check("selftest clr", statusData[6], 1'h0);
		strobe(4'h2);
		check("crc", statusData[9], 1'h1);
		strobe(4'h1);
		check("no command", statusData[9], 1'h1);
		strobe(4'h5);
		check("same cycle", statusData[9], 1'h1);
		strobe(4'h1);
		check("crc clr", statusData[9], 1'h0);
		// empty, whole, short, then random frame lengths
		for (int i = 0; i < 7; i++) begin
			n = i < 2 ? i * 16 : i == 2 ? 15 : 1 + ($random(seed) & 32'h2F);
			u_host.frame(n);
			check("frame", statusData[9], bad(n));
			strobe(4'h4);
			strobe(4'h1);
			check("frame clr", statusData[9], 1'h0);
		end
		// reset in mid-run wipes the undervoltage and spi sticky flags set just before it
		flt[0] = 1'h1;
		strobe(4'h2);
		check("pre reset", statusData[13] & statusData[9], 1'h1);
		flt[0] = 1'h0;
		rst_n = 1'h0;
		wt(2);
		check("in reset", statusData, 16'h0000);
		rst_n = 1'h1;
		wt(6);
		check("after reset", statusData, 16'h0000);
		results;
	end
endmodule
`default_nettype wire
